// file: pkg/pc_seq_pkg.sv
// Package for the program counter sequencer: widths, vectors, offsets, timing.
// Assumes a single 100 MHz system clock drives the sequencer.
package pc_seq_pkg;

  // ****************************************************************
  // Widths and geometry
  // ****************************************************************
  localparam int unsigned PTR_W        = 12;
  localparam int unsigned WORD_W       = 15;
  localparam int unsigned STACK_DEPTH  = 16;
  localparam int unsigned STACK_PTR_W  = 5;
  localparam int unsigned NUM_IRQ      = 6;
  localparam int unsigned PHASES       = 4;

  // ****************************************************************
  // Vectors
  // ****************************************************************
  localparam logic [11:0] VEC_RESET    = 12'h000;
  localparam logic [11:0] VEC_BUS      = 12'h004;
  localparam logic [11:0] VEC_TMR0     = 12'h008;
  localparam logic [11:0] VEC_TMR1     = 12'h00c;
  localparam logic [11:0] VEC_PLAY     = 12'h010;
  localparam logic [11:0] VEC_SERIAL   = 12'h014;
  localparam logic [11:0] VEC_RECORD   = 12'h018;

  // ****************************************************************
  // Register map (word index; byte address is index times four)
  // ****************************************************************
  localparam logic [7:0]  IDX_PCL      = 8'h06;
  localparam logic [7:0]  IDX_STATUS   = 8'h20;
  localparam logic [7:0]  IDX_IRQ_EN   = 8'h21;
  localparam logic [7:0]  IDX_CTRL     = 8'h22;
  localparam logic [5:0]  IRQ_EN_RESET = 6'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS        = 10;
  localparam int unsigned STARTUP_DELAY_CYCLES = 1024;
  localparam logic [10:0] STARTUP_RESET        = 11'h000;
  localparam logic [1:0]  PHASE_LAST           = 2'h3;

  typedef enum logic [1:0] {
    SEQ_WAIT  = 2'b00,
    SEQ_FILL  = 2'b01,
    SEQ_RUN   = 2'b10
  } seq_state_t;

  typedef enum logic [2:0] {
    OP_NORMAL = 3'b000,
    OP_SKIP   = 3'b001,
    OP_JUMP   = 3'b010,
    OP_CALL   = 3'b011,
    OP_RET    = 3'b100
  } seq_op_t;

endpackage

// file: rtl/program_counter_sequencer.sv
// Program counter sequencer: phase generator, fetch/execute pipeline, pointer update,
// return stack and a classic Wishbone slave for the pointer low byte and control.
// Assumes the program ROM answers combinationally within one instruction cycle and
// the decoder reports its operation on execute phase 3 via execOp.
//
// Operation
// - The system clock is split into four phases so each instruction cycle is four clocks.
// - Fetch of the next word overlaps execution of the previous one, one instruction a cycle.
// - Any pointer change other than increment costs two cycles, the second a dummy.
// - After each fetch the instruction pointer advances by one.
// - A true skip discards the fetched word as a dummy cycle, the pointer gaining two.
// - The low-byte register reads the pointer and a write replaces bits 7 to 0 only.
// - Jump and call load all twelve pointer bits from the instruction word.
// - A return reloads all twelve pointer bits from the top of the return stack.
// - Reset and interrupts load the fixed vectors 000, 004, 008, 00c, 010, 014, 018.
// - After reset release execution waits 1024 system clocks, then one four-clock instruction cycle, before the first fetch.
// - Call pushes the current pointer, interrupt acknowledge the pointer less one, on the edge that loads the target.
// - An interrupt is taken only when enabled and the stack is not full, else it pends.
`timescale 1ns/100ps
`default_nettype none

module program_counter_sequencer
  import pc_seq_pkg::*;
(
  input  wire logic                        clk_sys,
  input  wire logic                        arst_n,
  // Wishbone classic slave.
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [9:0]                  wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  // Program ROM.
  output logic      [pc_seq_pkg::PTR_W-1:0]  romAddr,
  input  wire logic [pc_seq_pkg::WORD_W-1:0] romData,
  // Decoder.
  output logic      [pc_seq_pkg::WORD_W-1:0] execWord,
  output logic                             execValid,
  output logic      [1:0]                  phase,
  input  wire logic [2:0]                  execOp,
  input  wire logic                        skipTrue,
  // Interrupt requests, one pulse or level per source.
  input  wire logic [pc_seq_pkg::NUM_IRQ-1:0] irqReq
);
  import pc_seq_pkg::*;

  // ****************************************************************
  // Phase generator and start-up delay
  // ****************************************************************
  logic [1:0]         phase_reg;
  logic [10:0]        startup_reg;
  seq_state_t         state_reg;
  logic               cycleEnd;
  logic               started;

  assign started  = (startup_reg == 11'(STARTUP_DELAY_CYCLES));
  assign cycleEnd = started && (phase_reg == PHASE_LAST);

  // Start-up counter holds execution off after reset; it saturates at the full count.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      startup_reg <= STARTUP_RESET;
    end else if (!started) begin
      startup_reg <= startup_reg + 11'h001;
    end
  end

  // Four phases per instruction cycle; the counter only runs once started.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      phase_reg <= 2'h0;
    end else if (started) begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic               wbHit;
  logic               pclWrite;
  logic [7:0]         pclData_reg;
  logic               pclPend_reg;
  logic [5:0]         irqEn_reg;
  logic [7:0]         wordIdx;
  logic [5:0]         irqPend_reg;
  logic [4:0]         stackCnt_reg;
  logic               pclApply;

  assign wordIdx  = wb_adr_i[9:2];
  assign wbHit    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign pclWrite = wbHit && wb_we_i && wb_sel_i[0] && (wordIdx == IDX_PCL);

  // Single-wait-state ack; unmapped words read zero and ignore writes.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wbHit;
      wb_dat_o <= 32'h0000_0000;
      if (wbHit && !wb_we_i) begin
        case (wordIdx)
          IDX_PCL:    wb_dat_o <= {24'h000000, romAddr[7:0]};
          IDX_STATUS: wb_dat_o <= {18'h0_0000, stackCnt_reg, irqPend_reg, phase_reg, started};
          IDX_IRQ_EN: wb_dat_o <= {26'h0000000, irqEn_reg};
          default:    wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Enable mask for interrupt sources.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irqEn_reg <= IRQ_EN_RESET;
    end else if (wbHit && wb_we_i && wb_sel_i[0] && wordIdx == IDX_IRQ_EN) begin
      irqEn_reg <= wb_dat_i[5:0];
    end
  end

  // A low-byte write is held until a cycle boundary at which no higher-priority load wins,
  // so it is never lost; a later write before then overwrites the earlier one.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pclPend_reg <= 1'b0;
      pclData_reg <= 8'h00;
    end else if (pclWrite) begin
      pclPend_reg <= 1'b1;
      pclData_reg <= wb_dat_i[7:0];
    end else if (cycleEnd && state_reg != SEQ_WAIT && pclApply) begin
      pclPend_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Interrupt pending flags
  // ****************************************************************
  logic [5:0]         irqTake;
  logic               stackFull;
  logic               takeIrq;
  logic [2:0]         irqSel;

  assign stackFull = (stackCnt_reg == 5'(STACK_DEPTH));
  assign irqTake   = irqPend_reg & irqEn_reg;
  assign takeIrq   = (irqTake != 6'h00) && !stackFull && execValid;

  // Lowest numbered source has priority.
  always_comb begin
    irqSel = 3'h0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (irqTake[i]) begin
        irqSel = 3'(i);
      end
    end
  end

  // Requests stay pending until acknowledged; a new request beats the clear.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irqPend_reg <= 6'h00;
    end else begin
      irqPend_reg <= (irqPend_reg & ~((cycleEnd && takeIrq) ? (6'h01 << irqSel) : 6'h00))
                     | irqReq;
    end
  end

  // ****************************************************************
  // Return stack
  // ****************************************************************
  logic [11:0]        stack_mem [STACK_DEPTH];
  logic [3:0]         stackTop_reg;
  logic               doPush;
  logic               doPop;
  seq_op_t            op;

  assign op     = seq_op_t'(execOp);
  assign doPush = cycleEnd && execValid && (takeIrq || op == OP_CALL);
  assign doPop  = cycleEnd && execValid && !takeIrq && op == OP_RET;

  // Circular stack: a call into a full stack overwrites the oldest entry.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stackTop_reg <= 4'h0;
      stackCnt_reg <= 5'h00;
    end else if (doPush) begin
      stackTop_reg <= stackTop_reg + 4'h1;
      if (!stackFull) begin
        stackCnt_reg <= stackCnt_reg + 5'h01;
      end
    end else if (doPop && stackCnt_reg != 5'h00) begin
      stackTop_reg <= stackTop_reg - 4'h1;
      stackCnt_reg <= stackCnt_reg - 5'h01;
    end
  end

  // A call pushes the address after it; an interrupt replaces the word in execute, so it
  // pushes that word's address and the replaced instruction still runs after the return.
  always_ff @(posedge clk_sys) begin
    if (doPush) begin
      stack_mem[stackTop_reg] <= takeIrq ? (romAddr - 12'h001) : romAddr;
    end
  end

  // ****************************************************************
  // Pointer update and pipeline
  // ****************************************************************
  logic [11:0]        ptrNext;
  logic               flush;
  logic [11:0]        vecTable [NUM_IRQ];

  assign vecTable[0] = VEC_BUS;
  assign vecTable[1] = VEC_TMR0;
  assign vecTable[2] = VEC_TMR1;
  assign vecTable[3] = VEC_PLAY;
  assign vecTable[4] = VEC_SERIAL;
  assign vecTable[5] = VEC_RECORD;

  // Select the next pointer; every non-increment source flushes the fetched word.
  always_comb begin
    ptrNext  = romAddr + 12'h001;
    flush    = 1'b0;
    pclApply = 1'b0;
    if (execValid && takeIrq) begin
      ptrNext = vecTable[irqSel];
      flush   = 1'b1;
    end else if (execValid && op == OP_JUMP || execValid && op == OP_CALL) begin
      ptrNext = execWord[11:0];
      flush   = 1'b1;
    end else if (execValid && op == OP_RET) begin
      ptrNext = stack_mem[stackTop_reg - 4'h1];
      flush   = 1'b1;
    end else if (execValid && op == OP_SKIP && skipTrue) begin
      flush   = 1'b1;
    end else if (pclPend_reg) begin
      ptrNext  = {romAddr[11:8], pclData_reg};
      flush    = 1'b1;
      pclApply = 1'b1;
    end
  end

  // Sequencer: wait for start-up, fill the pipe once, then run one word per cycle.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= SEQ_WAIT;
      romAddr   <= VEC_RESET;
      execWord  <= 15'h0000;
      execValid <= 1'b0;
    end else if (cycleEnd) begin
      case (state_reg)
        SEQ_WAIT: begin
          state_reg <= SEQ_FILL;
          execWord  <= romData;
          execValid <= 1'b1;
          romAddr   <= romAddr + 12'h001;
        end
        SEQ_FILL, SEQ_RUN: begin
          state_reg <= SEQ_RUN;
          romAddr   <= ptrNext;
          execWord  <= romData;
          execValid <= !flush;
        end
        default: begin
          state_reg <= SEQ_WAIT;
        end
      endcase
    end
  end

  // Phase is exported registered for the decoder.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      phase <= 2'h0;
    end else begin
      phase <= phase_reg;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  phase_steps_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cycleEnd |=> !cycleEnd [*3] ##1 cycleEnd)
    else $error("Instruction cycle is not four clocks.");

  startup_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !started |-> !execValid && romAddr == VEC_RESET)
    else $error("Execution began before start-up delay.");

  ptr_incr_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cycleEnd && state_reg != SEQ_WAIT && !flush |=> romAddr == $past(romAddr) + 12'h001)
    else $error("Pointer did not advance by one.");

  jump_load_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cycleEnd && execValid && !takeIrq && op == OP_JUMP
    |=> romAddr == $past(execWord[11:0]))
    else $error("Jump target not loaded.");

  flush_dummy_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cycleEnd && state_reg != SEQ_WAIT && flush |=> !execValid [*4])
    else $error("Flushed word reached execution.");

  skip_two_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cycleEnd && execValid && !takeIrq && op == OP_SKIP && skipTrue && !pclPend_reg
    |=> romAddr == $past(romAddr) + 12'h001 && !execValid)
    else $error("Skip did not discard next word.");

  pcl_page_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cycleEnd && state_reg != SEQ_WAIT && pclPend_reg && !execValid
    |=> romAddr == {$past(romAddr[11:8]), $past(pclData_reg)})
    else $error("Low-byte write left the page.");

  irq_gate_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    doPush && op != OP_CALL |-> !stackFull && (irqPend_reg & irqEn_reg) != 6'h00)
    else $error("Interrupt taken while masked or stack full.");

  push_count_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    doPush && !stackFull |=> stackCnt_reg == $past(stackCnt_reg) + 5'h01)
    else $error("Call did not push the pointer.");

endmodule

`default_nettype wire

// file: bench/prog_rom_model.sv
// Program ROM and instruction decoder model that stands beside the sequencer.
// Assumes word bits 14:12 carry the operation and bits 11:0 the target.
`timescale 1ns/100ps
`default_nettype none

module prog_rom_model
  import pc_seq_pkg::*;
(
  input  wire logic [pc_seq_pkg::PTR_W-1:0]  romAddr,
  output logic      [pc_seq_pkg::WORD_W-1:0] romData,
  input  wire logic [pc_seq_pkg::WORD_W-1:0] execWord,
  input  wire logic                          execValid,
  output logic      [2:0]                    execOp,
  output logic                               skipTrue
);
  // ****************************************************************
  // Program image
  // ****************************************************************
  logic [14:0] mem [4096];

  // Jump, call, true skip, return and a tight loop; every interrupt vector returns at once.
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 15'h0000;
    end
    mem[12'h001] = {OP_JUMP, 12'h100};
    mem[12'h100] = {OP_CALL, 12'h200};
    mem[12'h200] = {OP_SKIP, 12'h001};
    mem[12'h202] = {OP_RET, 12'h000};
    mem[12'h102] = {OP_JUMP, 12'h102};
    mem[12'h140] = {OP_JUMP, 12'h140};
    for (int i = 1; i < 7; i++) begin
      mem[i * 4] = {OP_RET, 12'h000};
    end
  end

  // The ROM answers at once; a dummy word decodes as a plain instruction.
  assign romData  = mem[romAddr];
  assign execOp   = execValid ? execWord[14:12] : 3'h0;
  assign skipTrue = execWord[0];
endmodule

`default_nettype wire

// file: bench/program_counter_sequencer_test.sv
// Self-checking bench for the program counter sequencer.
// Assumes the ROM model beside it and a 100 MHz clock.
`timescale 1ns/100ps
`default_nettype none

module program_counter_sequencer_test;
  import pc_seq_pkg::*;
  logic        clk_sys = 1'b0;
  logic        arst_n  = 1'b0;
  logic        wbCyc   = 1'b0;
  logic        wbStb   = 1'b0;
  logic        wbWe    = 1'b0;
  logic [9:0]  wbAdr   = 10'h000;
  logic [3:0]  wbSel   = 4'h0;
  logic [31:0] wbDatI  = 32'h0;
  logic [31:0] wbDatO, rd;
  logic        wbAck, execValid, skipTrue;
  logic [11:0] romAddr, lastAddr = 12'h000;
  logic [14:0] romData, execWord;
  logic [2:0]  execOp;
  logic [1:0]  phase;
  logic [5:0]  irqReq  = 6'h00;
  logic [4095:0] visited = '0;
  logic [12:0] trace [$];
  int          gaps [$];
  int          gap = 0;
  int          errCount = 0;
  int          checksDone = 0;
  // Expected {pointer, valid} after each instruction cycle from the first fetch.
  logic [12:0] rows [13] = '{13'h003, 13'h005, 13'h200, 13'h203, 13'h400, 13'h403,
                             13'h404, 13'h407, 13'h202, 13'h205, 13'h207, 13'h204, 13'h207};
  logic [11:0] vecs [6] = '{VEC_BUS, VEC_TMR0, VEC_TMR1, VEC_PLAY, VEC_SERIAL, VEC_RECORD};

  program_counter_sequencer dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .romAddr(romAddr), .romData(romData),
    .execWord(execWord), .execValid(execValid), .phase(phase), .execOp(execOp),
    .skipTrue(skipTrue), .irqReq(irqReq));

  prog_rom_model rom (
    .romAddr(romAddr), .romData(romData), .execWord(execWord),
    .execValid(execValid), .execOp(execOp), .skipTrue(skipTrue));

  // ****************************************************************
  // Clock, trace monitor and shared tasks
  // ****************************************************************
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // Records every pointer move after the edge has settled, with its clock gap.
  always @(posedge clk_sys) begin
    #1;
    gap = gap + 1;
    if (romAddr !== lastAddr) begin
      trace.push_back({romAddr, execValid});
      gaps.push_back(gap);
      visited[romAddr] = 1'b1;
      gap = 0;
    end
    lastAddr = romAddr;
  end

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      errCount++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle, entered just after a rising edge; holds until ack is sampled.
  task automatic wb_xfer(input logic we, input logic [9:0] adr, input logic [3:0] sel,
                         input logic [31:0] wdat);
    int n;
    n = 0;
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= adr;
    wbSel  <= sel;
    wbDatI <= wdat;
    @(posedge clk_sys);
    while (wbAck !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    rd = wbDatO;
    if (n == 50) begin
      errCount++;
      $display("ERROR %0t: bus answer timed out", $time);
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (1020) @(posedge clk_sys);
    check_val(romAddr, 32'h0);
    repeat (80) @(posedge clk_sys);
    for (int i = 0; i < 13; i++) begin
      check_val(trace[i], rows[i]);
      if (i > 0) begin
        check_val(gaps[i], PHASES);
      end
    end
    // The exported phase lags by one clock, so it shows the last phase after a boundary.
    @(romAddr);
    #1;
    check_val(phase, PHASE_LAST);
    @(posedge clk_sys);
    $display("Program flow test done");
    // Interrupts stay pending while masked, then each vector is taken and returns.
    wb_xfer(1'b0, {IDX_IRQ_EN, 2'b00}, 4'hf, 32'h0);
    check_val(rd, {26'h0, IRQ_EN_RESET});
    irqReq <= 6'h01;
    @(posedge clk_sys);
    irqReq <= 6'h00;
    repeat (40) @(posedge clk_sys);
    check_val(visited[VEC_BUS], 1'b0);
    wb_xfer(1'b1, {IDX_IRQ_EN, 2'b00}, 4'h1, 32'h3f);
    for (int k = 0; k < 6; k++) begin
      irqReq <= 6'h01 << k;
      @(posedge clk_sys);
      irqReq <= 6'h00;
      repeat (60) @(posedge clk_sys);
      check_val(visited[vecs[k]], 1'b1);
      check_val(romAddr[11:1], 11'h081);
    end
    $display("Interrupt test done");
    // Low-byte register: read back, short jump inside the page, refused writes.
    wb_xfer(1'b0, {IDX_PCL, 2'b00}, 4'hf, 32'h0);
    check_val(rd & 32'hffff_fffe, 32'h2);
    wb_xfer(1'b1, {IDX_PCL, 2'b00}, 4'h1, 32'h40);
    repeat (40) @(posedge clk_sys);
    check_val({visited[12'h140], visited[12'h040]}, 2'b10);
    wb_xfer(1'b1, {IDX_PCL, 2'b00}, 4'h0, 32'h80);
    wb_xfer(1'b0, 10'h3fc, 4'hf, 32'h0);
    check_val(rd, 32'h0);
    repeat (40) @(posedge clk_sys);
    check_val(visited[12'h180], 1'b0);
    // Status: started, nothing pending, stack empty; the phase field is masked off.
    wb_xfer(1'b0, {IDX_STATUS, 2'b00}, 4'hf, 32'h0);
    check_val(rd & 32'hffff_fff9, 32'h1);
    $display("Register test done");
    // Reset in mid-run returns to the reset vector and waits out start-up again.
    arst_n <= 1'b0;
    @(posedge clk_sys);
    #1;
    check_val({romAddr, execValid}, 13'h0);
    @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (1020) @(posedge clk_sys);
    check_val(romAddr, 32'h0);
    repeat (20) @(posedge clk_sys);
    check_val(romAddr != 12'h000, 1'b1);
    $display("Reset test done");
    final_report();
  end

  // Whole run needs about 2650 clocks; this cuts a hang well after that.
  initial begin
    repeat (20000) @(posedge clk_sys);
    errCount++;
    $display("ERROR %0t: watchdog expired", $time);
    final_report();
  end
endmodule

`default_nettype wire
